// File: src/wgt_pkg.sv
package wgt_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_RELOAD = 12'h004;
  localparam logic [11:0] OFS_FEED = 12'h008;
  localparam logic [11:0] OFS_COUNT = 12'h00c;
  localparam logic [11:0] OFS_WARN = 12'h010;
  localparam logic [11:0] OFS_WINDOW = 12'h014;
  localparam logic [11:0] OFS_STATUS = 12'h018;
  localparam logic [11:0] OFS_MASK = 12'h01c;
  localparam logic [11:0] OFS_CLKDIV = 12'h020;
  // ----------------------------------------------------------------
  // mode register bit positions
  // ----------------------------------------------------------------
  localparam int MODE_EN = 0;
  localparam int MODE_RESET = 1;
  localparam int MODE_PROTECT = 2;
  localparam int MODE_WINDOW = 3;
  localparam int MODE_SLEEP_RUN = 4;
  localparam int MODE_DEBUG_RUN = 5;
  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int ST_TIMEOUT = 0;
  localparam int ST_WARN = 1;
  localparam int ST_WINERR = 2;
  localparam int ST_FEEDERR = 3;
  localparam int ST_WDRESET = 4;
  // ----------------------------------------------------------------
  // reset values, keys and counts
  // ----------------------------------------------------------------
  localparam logic [23:0] RELOAD_RST = 24'hffffff;
  localparam logic [23:0] WINDOW_RST = 24'hffffff;
  localparam logic [9:0] WARN_RST = 10'h000;
  localparam logic [23:0] RELOAD_MIN = 24'h0000ff;
  localparam logic [7:0] FEED_KEY1 = 8'haa;
  localparam logic [7:0] FEED_KEY2 = 8'h55;
  localparam int PRESCALE = 4;
  localparam logic [7:0] CLKDIV_RST = 8'h00;
  localparam int RSTPULSE_CYC = 4;
  typedef enum logic [1:0] {FEED_IDLE, FEED_HALF} wgt_feed_e;
endpackage : wgt_pkg

// File: src/windowed_guard_timer.sv
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - enabled and not fed before time-out: pulse whole-chip reset
// - windowed mode: feed only while count is at or below window value
// - warning interrupt when count reaches programmed warning point
// - 24-bit down counter advanced by fixed divide-by-four prescaler
// - time-out from 1024 to over 67 million guard clocks, steps of four
// - enable cannot be cleared by software, only by reset
// - wrong feed sequence while enabled gives immediate event
// - protect mode: reload value changes only after warning point
// - status flag records reset caused by the guard timer
// - guard clock from 1 MHz oscillator through programmable divider
// - configurable to keep counting in deep sleep
module wgt_windowed_guard_timer
  import wgt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator tick and system state
  input wire logic osc1mTick,
  input wire logic deepSleep,
  input wire logic debugHalt,
  input wire logic wdResetSeen,
  // outputs
  output logic irq,
  output logic chipReset
);
  import wgt_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [5:0] mode_q;
  logic [23:0] reload_q;
  logic [23:0] count_q;
  logic [9:0] warn_q;
  logic [23:0] window_q;
  logic [4:0] status_q;
  logic [4:0] mask_q;
  logic [7:0] clkDiv_q;
  logic [7:0] divCnt_q;
  logic [1:0] pre_q;
  logic [2:0] rstCnt_q;
  wgt_feed_e feed_q;
  logic [2:0] oscSync_q;
  logic [1:0] sleepSync_q;
  logic [1:0] haltSync_q;
  logic [1:0] seenSync_q;
  logic wr;
  logic rd;
  logic wdTick;
  logic decTick;
  logic run;
  logic feedOk;
  logic feedBad;
  logic winBad;
  logic warnHit;
  logic timeout;
  logic fire;
  logic [4:0] evt;

  // warning point widened to the counter width
  function automatic logic [23:0] warnPoint(input logic [9:0] w);
    return {14'h000, w};
  endfunction : warnPoint

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // two flops before any logic reads pins
  // third oscillator flop only serves the rising-edge detect
  always_ff @(posedge clk) begin
    if (!rstn) begin
      oscSync_q <= 3'h0;
      sleepSync_q <= 2'h0;
      haltSync_q <= 2'h0;
      seenSync_q <= 2'h0;
    end else begin
      oscSync_q <= {oscSync_q[1:0], osc1mTick};
      sleepSync_q <= {sleepSync_q[0], deepSleep};
      haltSync_q <= {haltSync_q[0], debugHalt};
      seenSync_q <= {seenSync_q[0], wdResetSeen};
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // access-phase strobes; zero wait states, no error response
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ----------------------------------------------------------------
  // guard clock divider and prescaler
  // ----------------------------------------------------------------
  // rising edge of synced oscillator, then divide by clkDiv+1
  assign wdTick = oscSync_q[1] && !oscSync_q[2] && (divCnt_q >= clkDiv_q);
  // counting gated by enable, sleep and debug halt
  assign run = mode_q[MODE_EN]
             && (!sleepSync_q[1] || mode_q[MODE_SLEEP_RUN])
             && (!haltSync_q[1] || mode_q[MODE_DEBUG_RUN]);
  // one decrement per four guard ticks
  assign decTick = wdTick && run && (pre_q == 2'(PRESCALE - 1));

  // divider counter; wraps at or above the limit, so lowering the
  // divider while running never stalls the guard clock for a full wrap
  always_ff @(posedge clk) begin
    if (!rstn) begin
      divCnt_q <= 8'h00;
    end else if (oscSync_q[1] && !oscSync_q[2]) begin
      divCnt_q <= (divCnt_q >= clkDiv_q) ? 8'h00 : divCnt_q + 8'h01;
    end
  end

  // fixed divide-by-four prescaler
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pre_q <= 2'h0;
    end else if (feedOk) begin
      pre_q <= 2'h0;
    end else if (wdTick && run) begin
      pre_q <= pre_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // feed sequence
  // ----------------------------------------------------------------
  // second key right after the first completes the feed
  assign feedOk = wr && paddr == OFS_FEED && feed_q == FEED_HALF
                  && pwdata[7:0] == FEED_KEY2;
  // a first key followed by anything but the second, or a stray value
  assign feedBad = mode_q[MODE_EN] && wr && (
                   (feed_q == FEED_HALF && !feedOk) ||
                   (paddr == OFS_FEED && feed_q == FEED_IDLE
                    && pwdata[7:0] != FEED_KEY1));
  // early feed, warning point and expiry
  assign winBad = feedOk && mode_q[MODE_WINDOW] && count_q > window_q;
  assign warnHit = mode_q[MODE_EN] && count_q == warnPoint(warn_q);
  // count holds at zero, so each later decrement tick fires again
  assign timeout = decTick && count_q == 24'h000000;
  assign fire = timeout || feedBad || winBad;

  // feed state
  // any write between the two keys breaks the pair
  always_ff @(posedge clk) begin
    if (!rstn) begin
      feed_q <= FEED_IDLE;
    end else if (wr) begin
      if (feed_q == FEED_IDLE && paddr == OFS_FEED && pwdata[7:0] == FEED_KEY1) begin
        feed_q <= FEED_HALF;
      end else begin
        feed_q <= FEED_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // down counter
  // ----------------------------------------------------------------
  // reload on a good feed inside the window, else count down to zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_q <= RELOAD_RST;
    end else if (feedOk && !winBad) begin
      count_q <= reload_q;
    end else if (decTick && count_q != 24'h000000) begin
      count_q <= count_q - 24'h000001;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // mode register; enable and reset-mode bits are set-only
  // protect is set-only too; window and run bits stay writable
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_q <= 6'h00;
    end else if (wr && paddr == OFS_MODE) begin
      mode_q <= pwdata[5:0] | (mode_q & 6'h07);
    end
  end

  // reload value; floor keeps time-out at least 1024 guard clocks
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reload_q <= RELOAD_RST;
    end else if (wr && paddr == OFS_RELOAD
                 && (!mode_q[MODE_PROTECT] || count_q <= warnPoint(warn_q))) begin
      reload_q <= (pwdata[23:0] < RELOAD_MIN) ? RELOAD_MIN : pwdata[23:0];
    end
  end

  // warning point, window, mask, divider
  always_ff @(posedge clk) begin
    if (!rstn) begin
      warn_q <= WARN_RST;
      window_q <= WINDOW_RST;
      mask_q <= 5'h00;
      clkDiv_q <= CLKDIV_RST;
    end else if (wr) begin
      if (paddr == OFS_WARN) begin
        warn_q <= pwdata[9:0];
      end else if (paddr == OFS_WINDOW) begin
        window_q <= pwdata[23:0];
      end else if (paddr == OFS_MASK) begin
        mask_q <= pwdata[4:0];
      end else if (paddr == OFS_CLKDIV) begin
        clkDiv_q <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // status and interrupt
  // ----------------------------------------------------------------
  assign evt = {1'b0, feedBad, winBad, warnHit, timeout};

  // sticky bits; read clears, set wins over clear
  // a read clears only the bits it returned (captured in the setup
  // cycle), so an event landing between setup and access is kept
  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_q <= 5'h00;
    end else begin
      if (rd && paddr == OFS_STATUS) begin
        status_q <= (status_q & ~prdata[4:0]) | evt;
      end else begin
        status_q <= status_q | evt;
      end
      if (seenSync_q[1]) begin
        status_q[ST_WDRESET] <= 1'b1;
      end
    end
  end

  // level interrupt while any unmasked status bit is set
  assign irq = |(status_q & mask_q);

  // ----------------------------------------------------------------
  // chip reset pulse
  // ----------------------------------------------------------------
  // a new event restarts the pulse at full length
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rstCnt_q <= 3'h0;
    end else if (fire && mode_q[MODE_RESET]) begin
      rstCnt_q <= 3'(RSTPULSE_CYC);
    end else if (rstCnt_q != 3'h0) begin
      rstCnt_q <= rstCnt_q - 3'h1;
    end
  end

  // high for the whole pulse
  assign chipReset = rstCnt_q != 3'h0;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // captured in the setup cycle, held through the access phase
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == OFS_MODE) begin
        prdata <= {26'h0, mode_q};
      end else if (paddr == OFS_RELOAD) begin
        prdata <= {8'h00, reload_q};
      end else if (paddr == OFS_COUNT) begin
        prdata <= {8'h00, count_q};
      end else if (paddr == OFS_WARN) begin
        prdata <= {22'h0, warn_q};
      end else if (paddr == OFS_WINDOW) begin
        prdata <= {8'h00, window_q};
      end else if (paddr == OFS_STATUS) begin
        prdata <= {27'h0, status_q};
      end else if (paddr == OFS_MASK) begin
        prdata <= {27'h0, mask_q};
      end else if (paddr == OFS_CLKDIV) begin
        prdata <= {24'h0, clkDiv_q};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end
endmodule : wgt_windowed_guard_timer
`default_nettype wire

// File: verif/wgt_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------
// port checker
// --------------------------------------------
module wgt_monitor
  import wgt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // outputs
  input wire logic irq,
  input wire logic chipReset
);
  logic wr, rd, feed, bad, half_q, win_q;
  logic [2:0] stick_q;
  logic [4:0] mask_q;
  // access strobes and broken feed pairs
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign feed = wr && paddr == OFS_FEED;
  assign bad = wr && (half_q ? !(feed && pwdata[7:0] == FEED_KEY2)
                             : feed && pwdata[7:0] != FEED_KEY1);
  // feed half, set-only mode bits, mask (unknown until written)
  always_ff @(posedge clk) begin
    if (!rstn) begin
      half_q <= 1'b0;
      win_q <= 1'b0;
      stick_q <= 3'h0;
      mask_q <= 5'h1f;
    end else if (wr) begin
      half_q <= !half_q && feed && pwdata[7:0] == FEED_KEY1;
      if (paddr == OFS_MODE) stick_q <= stick_q | pwdata[2:0];
      if (paddr == OFS_MODE) win_q <= pwdata[MODE_WINDOW];
      if (paddr == OFS_MASK) mask_q <= pwdata[4:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_ready; psel |-> pready && !pslverr; endproperty
  a_ready: assert property (p_ready) else $error("apb answer not zero wait");
  property p_pulse; $rose(chipReset) |-> chipReset[*4] ##1 !chipReset; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse length wrong");
  property p_cause; $rose(chipReset) |-> stick_q[1]; endproperty
  a_cause: assert property (p_cause) else $error("reset without reset mode");
  property p_bad; bad && stick_q[1:0] == 2'h3 |-> ##[1:4] chipReset; endproperty
  a_bad: assert property (p_bad) else $error("bad feed gave no reset");
  property p_pair; feed && half_q && pwdata[7:0] == FEED_KEY2 && !win_q |=> !chipReset; endproperty
  a_pair: assert property (p_pair) else $error("good feed pair caused reset");
  property p_sticky; rd && paddr == OFS_MODE |-> (prdata[2:0] & stick_q) == stick_q; endproperty
  a_sticky: assert property (p_sticky) else $error("set-only mode bit cleared");
  property p_unmap; rd && paddr > OFS_CLKDIV |-> prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_mask; mask_q == 5'h00 |-> !irq; endproperty
  a_mask: assert property (p_mask) else $error("irq while all masked");
  c_reset: cover property ($rose(chipReset));
  c_irq: cover property ($rose(irq));
  c_bad: cover property (bad && stick_q[0]);
endmodule : wgt_monitor
bind wgt_windowed_guard_timer wgt_monitor i_mon (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .chipReset(chipReset));
`default_nettype wire

// File: verif/windowed_guard_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module windowed_guard_timer_tb;
  import wgt_pkg::*;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic osc1mTick = 0, debugHalt = 0, wdResetSeen = 0, deepSleep = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdV, v;
  logic pready, pslverr, irq, chipReset;
  int n_fail = 0, n_tests = 0, cyc = 0, i;
  wgt_windowed_guard_timer i_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc1mTick(osc1mTick), .deepSleep(deepSleep), .debugHalt(debugHalt),
    .wdResetSeen(wdResetSeen), .irq(irq), .chipReset(chipReset));
  // clock and a fast oscillator stand-in
  always #25 clk = ~clk;
  always begin
    repeat (4) @(posedge clk);
    osc1mTick <= ~osc1mTick;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      results();
    end
  end
  task chk(input string nm, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer, held until pready
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdV = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task rdc(input string nm, input logic [11:0] a, input logic [31:0] m, exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, exp, rdV & m);
  endtask : rdc
  task waitc(input int n);
    repeat (n) @(posedge clk);
  endtask : waitc
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  // --------------------------------------------
  // main sequence
  // --------------------------------------------
  initial begin
    waitc(8);
    rstn <= 1'b1;
    rdc("mode", OFS_MODE, '1, 32'h0);
    rdc("reload", OFS_RELOAD, '1, 32'hffffff);
    rdc("window", OFS_WINDOW, '1, 32'hffffff);
    rdc("clkdiv", OFS_CLKDIV, '1, 32'h0);
    xfer(1'b1, OFS_CLKDIV, 32'h3);
    rdc("clkdiv wr", OFS_CLKDIV, '1, 32'h3);
    xfer(1'b1, OFS_CLKDIV, 32'h0);
    rdc("unmapped", 12'h040, '1, 32'h0);
    wdResetSeen <= 1'b1;
    waitc(8);
    wdResetSeen <= 1'b0;
    waitc(8);
    rdc("flag", OFS_STATUS, 32'h10, 32'h10);
    rdc("flag clr", OFS_STATUS, 32'h10, 32'h0);
    xfer(1'b1, OFS_MASK, 32'h0);
    xfer(1'b1, OFS_RELOAD, 32'hff);
    xfer(1'b1, OFS_WARN, 32'h40);
    xfer(1'b1, OFS_MODE, 32'h3);
    xfer(1'b1, OFS_FEED, 32'haa);
    xfer(1'b1, OFS_FEED, 32'h55);
    xfer(1'b1, OFS_MODE, 32'h0);
    rdc("mode held", OFS_MODE, 32'h3, 32'h3);
    rdc("count", OFS_COUNT, 32'hffffff00, 32'h0);
    debugHalt <= 1'b1;
    waitc(4);
    xfer(1'b0, OFS_COUNT, 32'h0);
    v = rdV;
    waitc(200);
    rdc("halted", OFS_COUNT, '1, v);
    debugHalt <= 1'b0;
    deepSleep <= 1'b1;
    waitc(200);
    rdc("asleep", OFS_COUNT, '1, v);
    xfer(1'b1, OFS_MODE, 32'h30);
    waitc(200);
    xfer(1'b0, OFS_COUNT, 32'h0);
    chk("runs in sleep", 1'b1, rdV < v);
    v = rdV;
    deepSleep <= 1'b0;
    debugHalt <= 1'b1;
    waitc(200);
    xfer(1'b0, OFS_COUNT, 32'h0);
    chk("runs in debug", 1'b1, rdV < v);
    debugHalt <= 1'b0;
    xfer(1'b1, OFS_MODE, 32'h4);
    xfer(1'b1, OFS_RELOAD, 32'h1ff);
    rdc("protected", OFS_RELOAD, '1, 32'hff);
    for (i = 0; i < 500; i++) begin
      waitc(20);
      xfer(1'b0, OFS_COUNT, 32'h0);
      if (rdV < 32'h30) break;
    end
    chk("masked irq", 1'b0, irq);
    xfer(1'b1, OFS_MASK, 32'h2);
    waitc(1);
    chk("irq", 1'b1, irq);
    rdc("warn", OFS_STATUS, 32'h3, 32'h2);
    rdc("warn clr", OFS_STATUS, 32'h2, 32'h0);
    chk("irq clr", 1'b0, irq);
    xfer(1'b1, OFS_RELOAD, 32'h1ff);
    rdc("unprotected", OFS_RELOAD, '1, 32'h1ff);
    xfer(1'b1, OFS_WINDOW, 32'h10);
    xfer(1'b1, OFS_MODE, 32'h8);
    xfer(1'b1, OFS_FEED, 32'haa);
    xfer(1'b1, OFS_FEED, 32'h55);
    rdc("win err", OFS_STATUS, 32'h4, 32'h4);
    waitc(10);
    xfer(1'b1, OFS_FEED, 32'h12);
    for (i = 0; i < 4 && chipReset !== 1'b1; i++) @(posedge clk);
    chk("bad feed", 1'b1, chipReset);
    rdc("feed err", OFS_STATUS, 32'h8, 32'h8);
    waitc(8);
    for (i = 0; i < 20000 && chipReset !== 1'b1; i++) @(posedge clk);
    chk("time-out", 1'b1, chipReset);
    rdc("to flag", OFS_STATUS, 32'h1, 32'h1);
    rstn <= 1'b0;
    waitc(4);
    rstn <= 1'b1;
    rdc("mode after reset", OFS_MODE, '1, 32'h0);
    chk("pulse after reset", 1'b0, chipReset);
    results();
  end
endmodule : windowed_guard_timer_tb
`default_nettype wire
